/* ppoc_defines.vh */
// shared constants for the pulse output generator
`ifndef PPOC_DEFINES_VH
`define PPOC_DEFINES_VH
`define PPOC_CLK_HZ 200000000
`define PPOC_FREQ_MIN 16'h0001
`define PPOC_FREQ_MAX 16'h03e8
`define PPOC_DUTY_MIN 16'h0001
`define PPOC_DUTY_MAX 16'h0064
`define PPOC_FINE_LIMIT 16'h0032
`define PPOC_PRESET_MIN 32'h00000001
`define PPOC_PRESET_MAX 32'h05f5e100
`define PPOC_ERR_NONE 16'h0000
`define PPOC_ERR_FREQ 16'h0001
`define PPOC_ERR_DUTY 16'h0002
`define PPOC_ERR_PRESET 16'h0004
`define PPOC_OFS_FREQ 3'h0
`define PPOC_OFS_DUTY 3'h1
`define PPOC_OFS_PRE_HI 3'h2
`define PPOC_OFS_PRE_LO 3'h3
`define PPOC_OFS_CUR_HI 3'h4
`define PPOC_OFS_CUR_LO 3'h5
`define PPOC_OFS_ERR 3'h6
`define PPOC_ST_RUN 2'h0
`define PPOC_ST_DONE 2'h1
`define PPOC_ST_OVF 2'h2
`define PPOC_DEF_FREQ 16'h0064
`define PPOC_DEF_DUTY 16'h0032
`define PPOC_DEF_PRESET 32'h0000000a
`endif

/* ppoc_duty_quant.v */
// duty quantiser: raises requested on-ratio to the resolution step for the frequency
`timescale 1ns/10ps
`include "ppoc_defines.vh"
module ppoc_duty_quant (
  input wire [15:0] freq,
  input wire [15:0] duty,
  output reg [6:0] duty_q
);
  reg [15:0] step;
  reg [15:0] fsum;
  reg [15:0] dsum;
  reg [15:0] q;
  always @* begin
    fsum = freq + 16'h0031;
    dsum = 16'h0000;
    q = 16'h0000;
    if (freq <= `PPOC_FINE_LIMIT) begin
      step = 16'h0001;
    end else begin
      step = fsum / 16'h0032;
    end
    if (step != 16'h0000) begin
      dsum = duty + step - 16'h0001;
      q = (dsum / step) * step;
    end
    if (q > `PPOC_DUTY_MAX) begin
      q = `PPOC_DUTY_MAX;
    end
    duty_q = q[6:0];
  end
endmodule // ppoc_duty_quant

/* ppoc_load_model.sv */
// pulse load model: counts pulses and times the last high phase
`timescale 1ns/10ps
module ppoc_load_model (
  input wire clk,
  input wire pin,
  output int rises,
  output int high_len
);
  int run = 0;
  initial rises = 0;
  always @(posedge pin) rises++;
  always @(posedge clk) begin
    if (pin) run <= run + 1;
    else if (run != 0) begin
      high_len <= run;
      run <= 0;
    end
  end
endmodule // ppoc_load_model

/* ppoc_properties.sv */
// checker for the pulse output generator ports
`timescale 1ns/10ps
module ppoc_properties (
  input wire clk,
  input wire nrst,
  input wire exec_in,
  input wire [15:0] error_code_q,
  input wire [2:0] status_bits_q,
  input wire program_error_flag,
  input wire done_q,
  input wire pulse_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // five idle cycles cover the sync latency
  property p_done; !exec_in [*5] |-> !done_q; endproperty
  a_done: assert property (p_done) else $error("done while idle");
  property p_idle; !status_bits_q[0] [*2] |-> !pulse_q; endproperty
  a_idle: assert property (p_idle) else $error("pulse while stopped");
  property p_excl; !(status_bits_q[0] && status_bits_q[1]); endproperty
  a_excl: assert property (p_excl) else $error("run and complete");
  property p_ovf; !status_bits_q[2]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow set");
  property p_code; error_code_q inside {16'h0, 16'h1, 16'h2, 16'h4}; endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_flag; error_code_q != 16'h0 |-> ##[0:1] program_error_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag missing");
  property p_sticky; program_error_flag |=> program_error_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_start; $rose(status_bits_q[0]) |-> error_code_q == 16'h0; endproperty
  a_start: assert property (p_start) else $error("run with error");
endmodule // ppoc_properties
bind ppoc_pwm_gen ppoc_properties u_chk (.clk(clk), .nrst(nrst), .exec_in(exec_in),
  .error_code_q(error_code_q), .status_bits_q(status_bits_q),
  .program_error_flag(program_error_flag), .done_q(done_q), .pulse_q(pulse_q));

/* ppoc_pwm_gen.v */
// pulse-width pulse generator with optional pulse counting and status bits
// Notes on behaviour
// - frequency 1 to 1000 Hz in 1 Hz steps sets the pulse rate.
// - up to 50 Hz the on-ratio resolution is one percent.
// - from 51 Hz resolution is frequency over fifty, rounded up.
// - on-ratio between steps is raised to the next step multiple.
// - mode 0 pulses continuously while execution is on.
// - mode 1 emits exactly the preset count then stops.
// - counting only allowed on ports a and b.
// - emitted-pulse count register is refreshed every scan.
// - execution rise validates settings; errors set flag and code.
// - code 0 normal, 1 bad frequency, 2 bad on-ratio.
// - code 4 when counting and preset outside one to one hundred million.
// - valid rise sets running and starts pulses.
// - counting stops output once preset pulses emitted.
// - on-ratio changes apply from the next clock, even mid-pulse, without restart.
// - execution fall clears running and sets complete together.
// - while executing, initialisation input is ignored.
// - initialisation with execution off reloads defaults each scan.
// - seven words: freq, duty, preset hi/lo, count hi/lo, error.
// - status bits running, complete, overflow past preset.
// - done follows complete but is low while execution is off.
`timescale 1ns/10ps
`include "ppoc_defines.vh"
module ppoc_pwm_gen #(
  parameter [1:0] PORT_SEL = 2'h0,
  parameter CLK_HZ = `PPOC_CLK_HZ
) (
  input wire clk,
  input wire nrst,
  input wire exec_in,
  input wire default_load_input,
  input wire count_mode,
  input wire [2:0] wr_index,
  input wire wr_en,
  input wire [15:0] wr_data,
  output reg [15:0] freq_word_q,
  output reg [15:0] duty_word_q,
  output reg [15:0] preset_hi_q,
  output reg [15:0] preset_lo_q,
  output reg [15:0] count_hi_q,
  output reg [15:0] count_lo_q,
  output reg [15:0] error_code_q,
  output reg [2:0] status_bits_q,
  output reg program_error_flag,
  output reg done_q,
  output reg pulse_q
);
  localparam [31:0] CLK_W = CLK_HZ;
  // default preset split into its two words without silent truncation
  localparam [31:0] DEF_PRESET = `PPOC_DEF_PRESET;
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN = 3'b010;
  localparam [2:0] S_STOP = 3'b100;
  reg [2:0] sync_q;
  reg [2:0] state_q;
  reg [31:0] period_q;
  reg [31:0] tick_q;
  reg [31:0] emitted_q;
  reg [15:0] freq_run_q;
  reg counting_q;
  wire [6:0] duty_q7;
  wire exec_s;
  wire exec_prev;
  wire rise;
  wire fall;
  wire [31:0] preset;
  wire mode_ok;
  reg [15:0] err_d;
  wire [31:0] on_ticks;
  wire [31:0] period_of;
  assign exec_s = sync_q[1];
  assign exec_prev = sync_q[2];
  assign rise = exec_s & ~exec_prev;
  assign fall = ~exec_s & exec_prev;
  assign preset = {preset_hi_q, preset_lo_q};
  assign mode_ok = count_mode & (PORT_SEL < 2'h2);
  assign period_of = (freq_word_q == 16'h0000) ? CLK_W : CLK_W / {16'h0000, freq_word_q};
  // on ticks from the live duty word, so writes during running apply from the next clock, even mid-pulse
  assign on_ticks = (period_q / 32'h00000064) * {25'h0000000, duty_q7};

  ppoc_duty_quant u_quant (
    .freq(freq_run_q),
    .duty(duty_word_q),
    .duty_q(duty_q7)
  );

  // validation of settings on execution rise
  always @* begin
    err_d = `PPOC_ERR_NONE;
    if (freq_word_q < `PPOC_FREQ_MIN || freq_word_q > `PPOC_FREQ_MAX) begin
      err_d = `PPOC_ERR_FREQ;
    end else if (duty_word_q < `PPOC_DUTY_MIN || duty_word_q > `PPOC_DUTY_MAX) begin
      err_d = `PPOC_ERR_DUTY;
    end else if (mode_ok && (preset < `PPOC_PRESET_MIN || preset > `PPOC_PRESET_MAX)) begin
      err_d = `PPOC_ERR_PRESET;
    end
  end

  // exec pin: three flops, change counts while second and third differ
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1], sync_q[0], exec_in};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      period_q <= 32'h00000001;
      tick_q <= 32'h00000000;
      emitted_q <= 32'h00000000;
      freq_run_q <= `PPOC_DEF_FREQ;
      counting_q <= 1'b0;
      freq_word_q <= `PPOC_DEF_FREQ;
      duty_word_q <= `PPOC_DEF_DUTY;
      preset_hi_q <= DEF_PRESET[31:16];
      preset_lo_q <= DEF_PRESET[15:0];
      count_hi_q <= 16'h0000;
      count_lo_q <= 16'h0000;
      error_code_q <= `PPOC_ERR_NONE;
      status_bits_q <= 3'h0;
      program_error_flag <= 1'b0;
      done_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      // program writes into the control block
      if (wr_en) begin
        if (wr_index == `PPOC_OFS_FREQ) begin
          freq_word_q <= wr_data;
        end else if (wr_index == `PPOC_OFS_DUTY) begin
          duty_word_q <= wr_data;
        end else if (wr_index == `PPOC_OFS_PRE_HI) begin
          preset_hi_q <= wr_data;
        end else if (wr_index == `PPOC_OFS_PRE_LO) begin
          preset_lo_q <= wr_data;
        end
      end
      // defaults reload only while execution is off
      if (default_load_input && !exec_s) begin
        freq_word_q <= `PPOC_DEF_FREQ;
        duty_word_q <= `PPOC_DEF_DUTY;
        preset_hi_q <= DEF_PRESET[31:16];
        preset_lo_q <= DEF_PRESET[15:0];
        error_code_q <= `PPOC_ERR_NONE;
      end
      // count words mirror emitted pulses every cycle
      count_hi_q <= emitted_q[31:16];
      count_lo_q <= emitted_q[15:0];
      done_q <= status_bits_q[`PPOC_ST_DONE] & exec_s;
      case (state_q)
        S_IDLE, S_STOP: begin
          if (rise) begin
            error_code_q <= err_d;
            emitted_q <= 32'h00000000;
            tick_q <= 32'h00000000;
            status_bits_q[`PPOC_ST_OVF] <= 1'b0;
            if (err_d != `PPOC_ERR_NONE) begin
              program_error_flag <= 1'b1;
              state_q <= S_STOP;
            end else begin
              period_q <= period_of;
              freq_run_q <= freq_word_q;
              counting_q <= mode_ok;
              status_bits_q[`PPOC_ST_RUN] <= 1'b1;
              status_bits_q[`PPOC_ST_DONE] <= 1'b0;
              state_q <= S_RUN;
            end
          end else if (fall) begin
            status_bits_q[`PPOC_ST_RUN] <= 1'b0;
            status_bits_q[`PPOC_ST_DONE] <= 1'b1;
          end
        end
        S_RUN: begin
          if (fall) begin
            pulse_q <= 1'b0;
            status_bits_q[`PPOC_ST_RUN] <= 1'b0;
            status_bits_q[`PPOC_ST_DONE] <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            pulse_q <= (tick_q < on_ticks);
            if (tick_q >= period_q - 32'h00000001) begin
              tick_q <= 32'h00000000;
              emitted_q <= emitted_q + 32'h00000001;
              if (counting_q && emitted_q + 32'h00000001 >= preset) begin
                status_bits_q[`PPOC_ST_RUN] <= 1'b0;
                status_bits_q[`PPOC_ST_DONE] <= 1'b1;
                state_q <= S_STOP;
              end
              if (counting_q && emitted_q + 32'h00000001 > preset) begin
                status_bits_q[`PPOC_ST_OVF] <= 1'b1;
              end
            end else begin
              tick_q <= tick_q + 32'h00000001;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      if (state_q == S_STOP) begin
        pulse_q <= 1'b0;
      end
    end
  end
endmodule // ppoc_pwm_gen

/* pwm_pulse_output_counter_tb_top.sv */
// self-checking bench for the pulse output generator
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module pwm_pulse_output_counter_tb_top;
  logic clk, nrst, exec_in, default_load_input, count_mode, wr_en;
  logic [2:0] wr_index;
  logic [15:0] wr_data, freq_word_q, error_code_q, count_hi_q, count_lo_q;
  logic [2:0] status_bits_q, st_d;
  logic program_error_flag, done_q, pulse_q;
  int errors = 0, comparisons = 0, rises, high_len, r0;
  // short clock rate keeps periods between one hundred and two thousand cycles
  ppoc_pwm_gen #(.CLK_HZ(100000)) DUT (.clk(clk), .nrst(nrst), .exec_in(exec_in),
    .default_load_input(default_load_input), .count_mode(count_mode), .wr_index(wr_index),
    .wr_en(wr_en), .wr_data(wr_data), .freq_word_q(freq_word_q), .duty_word_q(),
    .preset_hi_q(), .preset_lo_q(), .count_hi_q(count_hi_q), .count_lo_q(count_lo_q),
    .error_code_q(error_code_q), .status_bits_q(status_bits_q),
    .program_error_flag(program_error_flag), .done_q(done_q), .pulse_q(pulse_q));
  // port d copy: counting mode must be ignored there
  ppoc_pwm_gen #(.PORT_SEL(2'h3), .CLK_HZ(100000)) DUT_D (.clk(clk), .nrst(nrst),
    .exec_in(exec_in), .default_load_input(default_load_input), .count_mode(count_mode),
    .wr_index(wr_index), .wr_en(wr_en), .wr_data(wr_data), .freq_word_q(), .duty_word_q(),
    .preset_hi_q(), .preset_lo_q(), .count_hi_q(), .count_lo_q(), .error_code_q(),
    .status_bits_q(st_d), .program_error_flag(), .done_q(), .pulse_q());
  ppoc_load_model m (.clk(clk), .pin(pulse_q), .rises(rises), .high_len(high_len));
  task wr(input [2:0] i, input [15:0] d);
    @(posedge clk); wr_index <= i; wr_data <= d; wr_en <= 1'b1;
    @(posedge clk); wr_en <= 1'b0;
    #1; // look after the edge's updates have settled
  endtask
  task ex(input v);
    @(posedge clk); exec_in <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task t_errs;
    logic [2:0] ix [5];
    logic [15:0] bad [5], good [5], code [5];
    ix = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3};
    bad = '{16'h0, 16'h3e9, 16'h0, 16'h65, 16'h0};
    good = '{16'h3e8, 16'h3e8, 16'h1e, 16'h1e, 16'h3};
    code = '{16'h1, 16'h1, 16'h2, 16'h2, 16'h4};
    for (int k = 0; k < 5; k++) begin
      wr(ix[k], bad[k]);
      ex(1);
      `CHK(error_code_q, code[k])
      `CHK(status_bits_q[0], 1'b0)
      ex(0);
      wr(ix[k], good[k]);
    end
    `CHK(program_error_flag, 1'b1)
  endtask
  task t_count;
    r0 = rises;
    ex(1);
    `CHK(status_bits_q, 3'h1)
    repeat (400) @(posedge clk);
    `CHK(rises - r0, 3)
    `CHK(high_len, 40)
    `CHK(status_bits_q, 3'h2)
    `CHK(st_d, 3'h1)
    `CHK({count_hi_q, count_lo_q}, 32'h3)
    `CHK(done_q, 1'b1)
    ex(0);
    `CHK(done_q, 1'b0)
  endtask
  task t_cont;
    count_mode <= 1'b0;
    wr(3'h0, 16'h32);
    wr(3'h1, 16'h21);
    ex(1);
    repeat (4100) @(posedge clk);
    `CHK(high_len, 660)
    wr(3'h1, 16'h3c);
    repeat (4100) @(posedge clk);
    `CHK(high_len, 1200)
    `CHK(status_bits_q[0], 1'b1)
    ex(0);
    `CHK(status_bits_q, 3'h2)
  endtask
  task t_init;
    default_load_input <= 1'b1;
    wr(3'h0, 16'h7);
    `CHK(freq_word_q, 16'h64)
    default_load_input <= 1'b0;
    wr(3'h0, 16'h200);
    ex(1);
    default_load_input <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(freq_word_q, 16'h200)
    default_load_input <= 1'b0;
    ex(0);
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    nrst = 0; exec_in = 0; default_load_input = 0; count_mode = 1;
    wr_en = 0; wr_index = 0; wr_data = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_errs; t_count; t_cont; t_init;
    end_of_test;
  end
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule // pwm_pulse_output_counter_tb_top
